/* rtl/ctm_cfg.svh */
// Offsets, field positions, reset values and timing counts of the
// counter/timer. Assumes inclusion by bare name from rtl/.
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CTM_OFS_CTRL 8'h00
`define CTM_OFS_GATE 8'h04
`define CTM_OFS_CMD 8'h08
`define CTM_OFS_RESULT 8'h0C
`define CTM_OFS_STATUS 8'h10
`define CTM_OFS_ISTAT 8'h14
`define CTM_OFS_IMASK 8'h18

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define CTM_CTRL_HOLD_BIT 3
`define CTM_CMD_ARM_BIT 0
`define CTM_MANT_W 27
`define CTM_GATE_W 14
`define CTM_IRQ_N 2
`define CTM_IRQ_DONE 0
`define CTM_IRQ_OVF 1

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define CTM_GATE_RST 14'h2710
`define CTM_GATE_MIN 14'h0001
`define CTM_GATE_MAX 14'h2710
`define CTM_TOT_MAX 27'h5F5_E0FF

// ----------------------------------------
// Timing, in ns, and derived cycle counts
// ----------------------------------------
`define CTM_CLK_NS 10
`define CTM_GATE_UNIT_NS 100000
`define CTM_PER_RES_NS 100
`define CTM_PW_RES_NS 10
`define CTM_PER_TICK_CYC (`CTM_PER_RES_NS / `CTM_CLK_NS)
`define CTM_GATE_UNIT_CYC (`CTM_GATE_UNIT_NS / `CTM_CLK_NS)
// Gate units per second, for the frequency scale
`define CTM_UNITS_PER_S 10000
// Nanoseconds per gate unit
`define CTM_NS_PER_UNIT 100000

// ----------------------------------------
// Decimal exponents of results
// ----------------------------------------
`define CTM_EXP_UNIT 5'h00
`define CTM_EXP_NS 5'h17
`define CTM_EXP_PER 5'h19
`define CTM_EXP_PW 5'h18

`endif

/* rtl/ctm_pkg.sv */
// Types shared by the counter/timer files.
// Assumes nothing of its surroundings.
package ctm_pkg;

	// ----------------------------------------
	// Measurement functions
	// ----------------------------------------
	typedef enum logic [2:0] {
		CTM_FREQ = 3'b000,
		CTM_PERIOD = 3'b001,
		CTM_AVG_PERIOD = 3'b010,
		CTM_PULSE = 3'b011,
		CTM_GATED_COUNT = 3'b100,
		CTM_OPEN_COUNT = 3'b101
	} ctm_func_t;

	// ----------------------------------------
	// Measurement sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		CTM_ST_IDLE = 3'b000,
		CTM_ST_ARMED = 3'b001,
		CTM_ST_MEAS = 3'b010,
		CTM_ST_CALC = 3'b011,
		CTM_ST_HELD = 3'b100
	} ctm_state_t;

endpackage

/* rtl/ctm_edge_sync.sv */
// Three-stage synchroniser with glitch check and edge pulses.
// Assumes sig_in is asynchronous to mclk.
`timescale 1ns/1ps
module ctm_edge_sync (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic sig_in,
	output logic level,
	output logic rise,
	output logic fall
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic level_reg;

	// ----------------------------------------
	// Synchroniser chain
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= sig_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Change counts only once stages two and three agree
	always_ff @(posedge mclk) begin
		if (!rstn)
			level_reg <= 1'b0;
		else if (s2_reg == s3_reg)
			level_reg <= s3_reg;
	end

	assign level = level_reg;
	assign rise = (s2_reg == s3_reg) && s3_reg && !level_reg;
	assign fall = (s2_reg == s3_reg) && !s3_reg && level_reg;
endmodule

/* rtl/ctm_top.sv */
// Counter/timer measuring an external trigger-input signal.
// Assumes a classic Wishbone master on mclk and an asynchronous input.
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "ctm_cfg.svh"

// Summary of operation
// - Six functions selectable; frequency after reset.
// - Only frequency, averaged period and gated count use the programmed gate; gated count ignores the display mode.
// - Frequency counts input cycles over the gate interval.
// - Single period times one input period at 100 ns resolution.
// - Averaged period is gate time over cycle count.
// - Pulse width timed at 10 ns resolution.
// - Gated count opens on first edge, holds until reset.
// - Open count runs from first edge until configuration changes.
// - Totals hold eight decimal digits; overflow is flagged.
// - Result read stalls the bus until a result exists.
// - Result is unsigned mantissa and signed decimal exponent.
// - Counter reset command clears and arms the counter.
// - Status reports the active function code.
// - Continuous mode rearms; hold mode takes one reading.
// - Gate from 100 us to 1 s in 100 us steps; 1 s at reset.
module ctm_top #(
	parameter int GATE_UNIT_CYC = `CTM_GATE_UNIT_CYC
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sig_in,
	output logic irq
);
	import ctm_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	ctm_func_t func_reg;
	ctm_state_t state_reg;
	logic hold_reg;
	logic [`CTM_GATE_W-1:0] gate_reg;
	logic [`CTM_MANT_W-1:0] mant_reg;
	logic [4:0] exp_reg;
	logic valid_reg;
	logic ovf_reg;
	logic [`CTM_MANT_W-1:0] cnt_reg;
	logic [`CTM_MANT_W-1:0] tick_reg;
	logic [`CTM_MANT_W-1:0] tick_next;
	logic tick_inc;
	logic [3:0] sub_reg;
	logic [16:0] unit_reg;
	logic [`CTM_GATE_W-1:0] units_reg;
	logic [39:0] quo_reg;
	logic [40:0] rem_reg;
	logic [31:0] dvs_reg;
	logic [5:0] bit_reg;
	logic [`CTM_IRQ_N-1:0] istat_reg;
	logic [`CTM_IRQ_N-1:0] imask_reg;
	logic [`CTM_IRQ_N-1:0] ev_set;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic in_level;
	logic in_rise;
	logic in_fall;
	logic acc;
	logic wr;
	logic cfg_wr;
	logic arm_cmd;
	logic gate_end;
	logic finish;
	logic cnt_wrap;
	logic [`CTM_GATE_W-1:0] gate_wdat;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Functions whose run is bounded by the gate timer
	function automatic logic uses_gate(input ctm_func_t f);
		uses_gate = (f == CTM_FREQ) || (f == CTM_AVG_PERIOD) ||
			(f == CTM_GATED_COUNT);
	endfunction

	function automatic logic is_count(input ctm_func_t f);
		is_count = (f == CTM_GATED_COUNT) || (f == CTM_OPEN_COUNT);
	endfunction

	function automatic logic func_ok(input logic [2:0] c);
		func_ok = (c <= 3'b101);
	endfunction

	// Inverse of the hold bit as it will stand after this write
	function automatic logic hold_reg_next_armed();
		if (wb_adr_i == `CTM_OFS_CTRL && wb_sel_i[0])
			hold_reg_next_armed = !wb_dat_i[`CTM_CTRL_HOLD_BIT];
		else
			hold_reg_next_armed = !hold_reg;
	endfunction

	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------
	// Sync and validate edges
	ctm_edge_sync u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.sig_in(sig_in),
		.level(in_level),
		.rise(in_rise),
		.fall(in_fall)
	);

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	// Hold off ack on result
	assign acc = wb_cyc_i && wb_stb_i && !ack_reg &&
		!(!wb_we_i && wb_adr_i == `CTM_OFS_RESULT && !valid_reg);
	// Writes land on the edge where the master sees ack
	assign wr = wb_cyc_i && wb_stb_i && ack_reg && wb_we_i;
	assign cfg_wr = wr && (wb_adr_i == `CTM_OFS_CTRL ||
		wb_adr_i == `CTM_OFS_GATE);
	assign arm_cmd = wr && wb_adr_i == `CTM_OFS_CMD && wb_sel_i[0] &&
		wb_dat_i[`CTM_CMD_ARM_BIT];

	always_ff @(posedge mclk) begin
		if (!rstn)
			ack_reg <= 1'b0;
		else
			ack_reg <= acc;
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rdat_reg <= 32'h0000_0000;
		end else if (acc) begin
			case (wb_adr_i)
				`CTM_OFS_CTRL:
					rdat_reg <= {28'h000_0000, hold_reg, func_reg};
				`CTM_OFS_GATE:
					rdat_reg <= {18'h0_0000, gate_reg};
				`CTM_OFS_RESULT:
					rdat_reg <= {exp_reg, mant_reg};
				`CTM_OFS_STATUS:
					rdat_reg <= {21'h00_0000, state_reg, 1'b0,
						func_reg, state_reg == CTM_ST_MEAS,
						state_reg == CTM_ST_ARMED, ovf_reg, valid_reg};
				`CTM_OFS_ISTAT:
					rdat_reg <= {30'h0000_0000, istat_reg};
				`CTM_OFS_IMASK:
					rdat_reg <= {30'h0000_0000, imask_reg};
				default:
					rdat_reg <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// ----------------------------------------
	// Configuration
	// ----------------------------------------
	// Clamp gate into range
	always_comb begin
		gate_wdat = wb_dat_i[`CTM_GATE_W-1:0];
		if (wb_dat_i[31:`CTM_GATE_W] != 18'h0_0000 ||
				gate_wdat > `CTM_GATE_MAX)
			gate_wdat = `CTM_GATE_MAX;
		else if (gate_wdat < `CTM_GATE_MIN)
			gate_wdat = `CTM_GATE_MIN;
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			func_reg <= CTM_FREQ;
			hold_reg <= 1'b0;
		end else if (wr && wb_adr_i == `CTM_OFS_CTRL && wb_sel_i[0]) begin
			// Unknown codes are ignored, old function kept
			if (func_ok(wb_dat_i[2:0]))
				func_reg <= ctm_func_t'(wb_dat_i[2:0]);
			hold_reg <= wb_dat_i[`CTM_CTRL_HOLD_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn)
			gate_reg <= `CTM_GATE_RST;
		else if (wr && wb_adr_i == `CTM_OFS_GATE && wb_sel_i[0])
			gate_reg <= gate_wdat;
	end

	// ----------------------------------------
	// Gate timer
	// ----------------------------------------
	// Gate length from register
	assign gate_end = (unit_reg == 17'(GATE_UNIT_CYC - 1)) &&
		(units_reg == gate_reg - `CTM_GATE_W'(1));

	always_ff @(posedge mclk) begin
		if (!rstn || state_reg != CTM_ST_MEAS) begin
			unit_reg <= 17'h0_0000;
			units_reg <= `CTM_GATE_W'(0);
		end else if (unit_reg == 17'(GATE_UNIT_CYC - 1)) begin
			unit_reg <= 17'h0_0000;
			units_reg <= units_reg + `CTM_GATE_W'(1);
		end else begin
			unit_reg <= unit_reg + 17'h0_0001;
		end
	end

	// ----------------------------------------
	// Event and time counters
	// ----------------------------------------
	// Eight decimal digits
	assign cnt_wrap = in_rise && cnt_reg == `CTM_TOT_MAX;

	always_ff @(posedge mclk) begin
		if (!rstn || state_reg == CTM_ST_ARMED)
			cnt_reg <= (state_reg == CTM_ST_ARMED && in_rise) ?
				`CTM_MANT_W'(1) : `CTM_MANT_W'(0);
		else if (state_reg == CTM_ST_MEAS && in_rise && !gate_end)
			cnt_reg <= cnt_wrap ? `CTM_MANT_W'(0) :
				cnt_reg + `CTM_MANT_W'(1);
	end

	// Prescaler for the coarse period tick
	always_ff @(posedge mclk) begin
		if (!rstn || state_reg != CTM_ST_MEAS)
			sub_reg <= 4'h0;
		else if (sub_reg == 4'(`CTM_PER_TICK_CYC - 1))
			sub_reg <= 4'h0;
		else
			sub_reg <= sub_reg + 4'h1;
	end

	assign tick_inc = (func_reg == CTM_PULSE) ||
		(sub_reg == 4'(`CTM_PER_TICK_CYC - 1));
	// Finishing edge keeps its own tick, so no cycle is lost
	assign tick_next = tick_reg + `CTM_MANT_W'(tick_inc);

	always_ff @(posedge mclk) begin
		if (!rstn || state_reg != CTM_ST_MEAS)
			tick_reg <= `CTM_MANT_W'(0);
		else if (tick_inc)
			tick_reg <= tick_next;
	end

	// ----------------------------------------
	// Measurement sequencer
	// ----------------------------------------
	// Gated count ends at gate
	always_comb begin
		case (func_reg)
			CTM_PERIOD: finish = in_rise;
			CTM_PULSE: finish = in_fall;
			CTM_OPEN_COUNT: finish = 1'b0;
			default: finish = gate_end;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_reg <= CTM_ST_ARMED;
		end else if (cfg_wr) begin
			state_reg <= hold_reg_next_armed() ? CTM_ST_ARMED :
				CTM_ST_IDLE;
		end else if (arm_cmd) begin
			state_reg <= CTM_ST_ARMED;
		end else begin
			case (state_reg)
				CTM_ST_IDLE:
					state_reg <= CTM_ST_IDLE;
				CTM_ST_ARMED:
					if (in_rise)
						state_reg <= CTM_ST_MEAS;
				CTM_ST_MEAS:
					if (finish)
						state_reg <= CTM_ST_CALC;
				CTM_ST_CALC:
					if (bit_reg == 6'h00) begin
						if (hold_reg || func_reg == CTM_GATED_COUNT)
							state_reg <= CTM_ST_HELD;
						else
							state_reg <= CTM_ST_ARMED;
					end
				CTM_ST_HELD:
					state_reg <= CTM_ST_HELD;
				default:
					state_reg <= CTM_ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Scaling divider
	// ----------------------------------------
	// Serial divide keeps area low; costs 40 cycles per result
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			quo_reg <= 40'h00_0000_0000;
			rem_reg <= 41'h000_0000_0000;
			dvs_reg <= 32'h0000_0001;
			bit_reg <= 6'h00;
		end else if (state_reg == CTM_ST_MEAS && finish) begin
			bit_reg <= 6'd40;
			rem_reg <= 41'h000_0000_0000;
			if (func_reg == CTM_FREQ) begin
				// Hz over gate, digits track gate
				quo_reg <= 40'(cnt_reg) * 40'(`CTM_UNITS_PER_S);
				dvs_reg <= 32'(gate_reg);
			end else if (func_reg == CTM_AVG_PERIOD) begin
				quo_reg <= 40'(gate_reg) * 40'(`CTM_NS_PER_UNIT);
				dvs_reg <= (cnt_reg == `CTM_MANT_W'(0)) ?
					32'h0000_0001 : 32'(cnt_reg);
			end else begin
				quo_reg <= 40'(cnt_reg);
				dvs_reg <= 32'h0000_0001;
			end
		end else if (state_reg == CTM_ST_CALC && bit_reg != 6'h00) begin
			bit_reg <= bit_reg - 6'h01;
			if ({rem_reg[39:0], quo_reg[39]} >= {9'h000, dvs_reg}) begin
				rem_reg <= {rem_reg[39:0], quo_reg[39]} -
					{9'h000, dvs_reg};
				quo_reg <= {quo_reg[38:0], 1'b1};
			end else begin
				rem_reg <= {rem_reg[39:0], quo_reg[39]};
				quo_reg <= {quo_reg[38:0], 1'b0};
			end
		end
	end

	// ----------------------------------------
	// Result register
	// ----------------------------------------
	// Mantissa and decimal exponent
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mant_reg <= `CTM_MANT_W'(0);
			exp_reg <= `CTM_EXP_UNIT;
		end else if (state_reg == CTM_ST_MEAS &&
				func_reg == CTM_OPEN_COUNT) begin
			mant_reg <= cnt_reg;
			exp_reg <= `CTM_EXP_UNIT;
		end else if (state_reg == CTM_ST_MEAS && finish) begin
			if (func_reg == CTM_PERIOD) begin
				mant_reg <= tick_next;
				exp_reg <= `CTM_EXP_PER;
			end else if (func_reg == CTM_PULSE) begin
				mant_reg <= tick_next;
				exp_reg <= `CTM_EXP_PW;
			end
		end else if (state_reg == CTM_ST_CALC && bit_reg == 6'h00 &&
				!(func_reg == CTM_PERIOD || func_reg == CTM_PULSE)) begin
			// Quotient above 27 bits saturates
			mant_reg <= (quo_reg[39:`CTM_MANT_W] != 13'h0000) ?
				{`CTM_MANT_W{1'b1}} : quo_reg[`CTM_MANT_W-1:0];
			exp_reg <= (func_reg == CTM_AVG_PERIOD) ? `CTM_EXP_NS :
				`CTM_EXP_UNIT;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn || cfg_wr || arm_cmd)
			valid_reg <= 1'b0;
		else if ((state_reg == CTM_ST_CALC && bit_reg == 6'h00) ||
				(state_reg == CTM_ST_MEAS && func_reg == CTM_OPEN_COUNT))
			valid_reg <= 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (!rstn || cfg_wr || arm_cmd)
			ovf_reg <= 1'b0;
		else if (state_reg == CTM_ST_MEAS && is_count(func_reg) &&
				cnt_wrap && !gate_end)
			ovf_reg <= 1'b1;
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	assign ev_set[`CTM_IRQ_DONE] = state_reg == CTM_ST_CALC &&
		bit_reg == 6'h00;
	assign ev_set[`CTM_IRQ_OVF] = state_reg == CTM_ST_MEAS &&
		is_count(func_reg) && cnt_wrap && !gate_end;

	// Set wins over a same-cycle write-one clear
	genvar gi;
	generate
		for (gi = 0; gi < `CTM_IRQ_N; gi = gi + 1) begin : g_irq
			always_ff @(posedge mclk) begin
				if (!rstn)
					istat_reg[gi] <= 1'b0;
				else if (ev_set[gi])
					istat_reg[gi] <= 1'b1;
				else if (wr && wb_adr_i == `CTM_OFS_ISTAT &&
						wb_sel_i[0] && wb_dat_i[gi])
					istat_reg[gi] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (!rstn)
			imask_reg <= 2'b00;
		else if (wr && wb_adr_i == `CTM_OFS_IMASK && wb_sel_i[0])
			imask_reg <= wb_dat_i[`CTM_IRQ_N-1:0];
	end

	assign irq = |(istat_reg & imask_reg);

	// Unused level kept for a future polarity option
	logic unused_level;
	assign unused_level = in_level;
endmodule

/* sim/ctm_top_properties.sv */
// Concurrent checks on the counter/timer ports.
// Assumes binding into ctm_top; one clock, mclk.
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module ctm_props #(
	parameter int GATE_UNIT_CYC = 10
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic sig_in,
	input wire logic irq
);
	logic rd_ack;
	logic req_new;
	assign rd_ack = wb_ack_o && !wb_we_i;
	assign req_new = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	a_ack_one_pulse: assert property (
		@(posedge mclk) disable iff (!rstn) wb_ack_o |=> !wb_ack_o)
		else $error("ack held beyond one cycle");
	a_ack_needs_req: assert property (
		@(posedge mclk) disable iff (!rstn) wb_ack_o |-> wb_cyc_i && wb_stb_i)
		else $error("ack without a request");
	a_cmd_write_fast: assert property (
		@(posedge mclk) disable iff (!rstn) req_new && wb_we_i |=> wb_ack_o)
		else $error("write not answered next cycle");
	a_reg_read_fast: assert property (
		@(posedge mclk) disable iff (!rstn)
		req_new && !wb_we_i && wb_adr_i != `CTM_OFS_RESULT |=> wb_ack_o)
		else $error("register read not answered next cycle");
	// Reset check has no disable: it watches the reset itself
	a_reset_quiet: assert property (
		@(posedge mclk) !rstn |=> !wb_ack_o && !irq && wb_dat_o == 32'h0)
		else $error("outputs active after reset");
	// ----------------------------------------
	// Read data
	// ----------------------------------------
	a_func_code_legal: assert property (
		@(posedge mclk) disable iff (!rstn)
		rd_ack && wb_adr_i == `CTM_OFS_CTRL |-> wb_dat_o[2:0] <= 3'h5)
		else $error("function code out of range");
	a_gate_clamped: assert property (
		@(posedge mclk) disable iff (!rstn) rd_ack && wb_adr_i == `CTM_OFS_GATE
		|-> wb_dat_o inside {[32'h0000_0001:32'h0000_2710]})
		else $error("gate outside its range");
	a_cmd_reads_zero: assert property (
		@(posedge mclk) disable iff (!rstn)
		rd_ack && wb_adr_i == `CTM_OFS_CMD |-> wb_dat_o == 32'h0)
		else $error("command register not zero");
	a_result_exp_ok: assert property (
		@(posedge mclk) disable iff (!rstn) rd_ack && wb_adr_i == `CTM_OFS_RESULT
		|-> wb_dat_o[31:27] inside {5'h00, 5'h17, 5'h18, 5'h19})
		else $error("result exponent unknown");
	// Interrupt only drops through a register write
	a_irq_fall_write: assert property (
		@(posedge mclk) disable iff (!rstn)
		$fell(irq) |-> $past(wb_ack_o && wb_we_i))
		else $error("interrupt dropped without a write");
endmodule
bind ctm_top ctm_props #(.GATE_UNIT_CYC(GATE_UNIT_CYC)) u_ctm_props (
	.mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.sig_in(sig_in), .irq(irq));

/* sim/ctm_sig_model.sv */
// Measured signal source with set high and low times.
// Assumes mclk only as a time base; changes on the falling edge.
`timescale 1ns/1ps
module ctm_sig_model (
	input wire logic mclk,
	input wire logic en,
	input wire logic [7:0] hi_cyc,
	input wire logic [7:0] lo_cyc,
	output logic sig
);
	logic [7:0] cnt_reg = 8'h00;
	initial sig = 1'b0;
	// period below gate
	// Idle low when off, so no stray edge opens a gate
	always @(negedge mclk) begin
		if (!en) begin
			sig <= 1'b0;
			cnt_reg <= 8'h00;
		end else if (cnt_reg + 8'd1 >= (sig ? hi_cyc : lo_cyc)) begin
			sig <= ~sig;
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_reg + 8'd1;
		end
	end
endmodule

/* sim/ctm_top_tb.sv */
// Self-checking bench for the counter/timer over Wishbone.
// Assumes ctm_top with a 10-cycle gate unit and the signal model.
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module ctm_top_tb;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic irq;
	logic sig_in;
	logic sig_en = 1'b0;
	logic [7:0] hi_cyc = 8'h0F;
	logic [7:0] lo_cyc = 8'h0F;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [31:0] res_tab [3];
	logic [31:0] fn_tab [3];
	logic [7:0] pw;
	int n_mismatch = 0;
	int cmp_count = 0;
	int seed_v;
	ctm_top #(.GATE_UNIT_CYC(10)) u_ctm_top (
		.mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.sig_in(sig_in), .irq(irq));
	ctm_sig_model u_ctm_sig_model (.mclk(mclk), .en(sig_en),
		.hi_cyc(hi_cyc), .lo_cyc(lo_cyc), .sig(sig_in));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] e);
		cmp_count++;
		if (seen !== e) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, e);
		end
	endtask
	task automatic end_of_test();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// No fixed latency assumed: wait for ack, watchdog ends a hang
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] dat);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= dat;
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] adr, input logic [31:0] e,
		input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		wb(1'b0, adr, 32'h0000_0000);
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		wb(1'b1, adr, d);
	endtask
	task automatic irq_is(input logic e);
		@(posedge mclk);
		#1;
		check({31'h0, irq}, {31'h0, e});
	endtask
	// ----------------------------------------
	// Clock, monitor and watchdog
	// ----------------------------------------
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) begin
		if (wb_cyc_i && !wb_we_i && wb_ack_o === 1'b1) begin
			check(wb_dat_o & msk_q.pop_front(), exp_q.pop_front());
		end
	end
	initial begin
		#500000;
		n_mismatch++;
		end_of_test();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed_v = $urandom(6480);
		pw = 8'd20 + 8'($urandom % 30);
		fn_tab = '{32'h0000_0000, 32'h0000_0002, 32'h0000_0001};
		res_tab = '{32'h0000_0DAC, 32'hB804_5C12, 32'hC800_0003};
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		rd(`CTM_OFS_CTRL, 32'h0000_0000, 32'h0000_000F);
		rd(`CTM_OFS_GATE, 32'h0000_2710, 32'hFFFF_FFFF);
		rd(`CTM_OFS_STATUS, 32'h0000_0104, 32'h0000_077F);
		rd(`CTM_OFS_CMD, 32'h0000_0000, 32'hFFFF_FFFF);
		wr(8'h1C, 32'hFFFF_FFFF);
		rd(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF);
		wr(`CTM_OFS_GATE, 32'h0000_0000);
		rd(`CTM_OFS_GATE, 32'h0000_0001, 32'hFFFF_FFFF);
		wr(`CTM_OFS_GATE, 32'h0001_FFFF);
		rd(`CTM_OFS_GATE, 32'h0000_2710, 32'hFFFF_FFFF);
		// Gate of 200 cycles against a 30-cycle input period
		wr(`CTM_OFS_GATE, 32'h0000_0014);
		wr(`CTM_OFS_ISTAT, 32'h0000_0003);
		wr(`CTM_OFS_IMASK, 32'h0000_0001);
		rd(`CTM_OFS_IMASK, 32'h0000_0001, 32'hFFFF_FFFF);
		irq_is(1'b0);
		sig_en <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			wr(`CTM_OFS_CTRL, fn_tab[i]);
			rd(`CTM_OFS_RESULT, res_tab[i], 32'hFFFF_FFFF);
		end
		irq_is(1'b1);
		hi_cyc <= pw;
		wr(`CTM_OFS_CTRL, 32'h0000_0003);
		rd(`CTM_OFS_RESULT, {5'h18, 19'h0, pw}, 32'hFFFF_FFFF);
		hi_cyc <= 8'h0F;
		wr(`CTM_OFS_CTRL, 32'h0000_000C);
		rd(`CTM_OFS_STATUS, 32'h0000_0040, 32'h0000_0770);
		wr(`CTM_OFS_CMD, 32'h0000_0001);
		rd(`CTM_OFS_RESULT, 32'h0000_0007, 32'hFFFF_FFFF);
		repeat (300) @(posedge mclk);
		rd(`CTM_OFS_RESULT, 32'h0000_0007, 32'hFFFF_FFFF);
		rd(`CTM_OFS_STATUS, 32'h0000_0441, 32'h0000_0773);
		rd(`CTM_OFS_ISTAT, 32'h0000_0001, 32'h0000_0003);
		wr(`CTM_OFS_IMASK, 32'h0000_0002);
		irq_is(1'b0);
		wr(`CTM_OFS_IMASK, 32'h0000_0001);
		irq_is(1'b1);
		wr(`CTM_OFS_ISTAT, 32'h0000_0001);
		irq_is(1'b0);
		wr(`CTM_OFS_CTRL, 32'h0000_0008);
		wr(`CTM_OFS_CMD, 32'h0000_0001);
		rd(`CTM_OFS_RESULT, 32'h0000_0DAC, 32'hFFFF_FFFF);
		rd(`CTM_OFS_STATUS, 32'h0000_0401, 32'h0000_0771);
		wr(`CTM_OFS_CTRL, 32'h0000_0005);
		repeat (100) @(posedge mclk);
		rd(`CTM_OFS_STATUS, 32'h0000_0251, 32'h0000_0771);
		wr(`CTM_OFS_CTRL, 32'h0000_0006);
		rd(`CTM_OFS_CTRL, 32'h0000_0005, 32'h0000_000F);
		@(posedge mclk);
		end_of_test();
	end
endmodule
